// ---- rtl/dss_control.sv ----
`timescale 1ns/1ps
// What this block does
// - Terminal start obeyed only when control source is remote; an open run/stop contact stops in local too.
// - Two-wire: start held closed, run while run/stop contact closed.
// - Three-wire: momentary opening of run/stop input stops, and stays stopped.
// - Three-wire: momentary start closure starts; running latches after release.
// - Starts run forward unless input C is programmed as reverse start and is closed.
// - Auto/manual steers speed source only; local/remote steers start/stop and auto/manual key usability.
// - Local mode: auto/manual key works with local or speed setting.
// - Auto/manual key change applies only if enter follows within three seconds.
// - Auto chosen but no reference input closed: stay auto, use keypad speed.
// - Status outputs show auto when auto chosen by key, despite keypad fallback.
// - Remote mode: key usable only with speed setting, else select inputs decide.
// - Select input set to auto: closed means auto, open means manual.
// - Any select input may choose voltage or current analog reference.
// - Inputs A, B, C may choose preset speeds one, two, three.
// - Any two preset inputs closed together choose preset speed four unless C is a closed voltage or current input.
// - Speed-down on A lowers setpoint while closed, running or stopped.
// - Speed-up on B raises setpoint while closed, only when running.
// - Several reference inputs closed: C beats B beats A.
// - Select input and status output functions come from configuration ports.
module dss_control
  import dss_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DSS_DEBOUNCE_CYC,
  parameter int CONFIRM_CYC = DSS_CONFIRM_CYC,
  parameter int TRIM_TICK_CYC = DSS_TRIM_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input dss_cfg_t cfg,
  input dss_contacts_t contacts_closed,
  input wire logic key_run,
  input wire logic key_stop,
  input wire logic key_automan,
  input wire logic key_enter,
  input wire logic [DSS_SPEED_W-1:0] trim_step,
  input wire logic [DSS_SPEED_W-1:0] min_freq,
  input wire logic [DSS_SPEED_W-1:0] max_freq,
  output dss_run_t run_state,
  output logic auto_mode,
  output dss_src_t speed_source,
  output logic [DSS_SPEED_W-1:0] trim_setpoint,
  output logic automan_pending,
  output logic sink_output_one,
  output logic sink_output_two,
  output logic relay_output
);

  localparam int CCW = $clog2(CONFIRM_CYC + 1);
  localparam int TCW = $clog2(TRIM_TICK_CYC + 1);

  initial begin
    if (DEBOUNCE_CYC < 1 || CONFIRM_CYC < 1 || TRIM_TICK_CYC < 1) begin
      $error("dss_control: counts must be at least one");
    end
    // The contact bundle and the filter width must agree
    if ($bits(dss_contacts_t) != DSS_NUM_CONTACTS) begin
      $error("dss_control: contact bundle width mismatch");
    end
    if (DSS_SPEED_W < 2) begin
      $error("dss_control: speed word too narrow");
    end
  end

  dss_contacts_t db;
  logic run_closed;
  logic start_closed;
  logic [2:0] sel;
  dss_sel_t fn [3];

  // Contact filtering
  // Bounce shorter than the hold window never reaches the decoders
  // sync and debounce
  dss_debounce #(
    .WIDTH(DSS_NUM_CONTACTS),
    .HOLD_CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw(contacts_closed),
    .clean(db)
  );

  assign run_closed = db.run_stop_input;
  assign start_closed = db.start_input;
  assign sel = {db.select_input_c, db.select_input_b, db.select_input_a};
  assign fn[0] = cfg.func_a;
  assign fn[1] = cfg.func_b;
  assign fn[2] = cfg.func_c;

  logic remote;
  logic start_closed_d_reg;
  logic start_rise;
  logic rev_closed_d_reg;
  logic rev_rise;
  logic rev_enabled;

  assign remote = (cfg.control_source == DSS_CTL_REMOTE);
  assign rev_enabled = (cfg.func_c == DSS_SEL_REV);
  // Edge memories reset to open, the idle level of an unwired contact
  assign start_rise = start_closed && !start_closed_d_reg;
  assign rev_rise = rev_enabled && db.select_input_c && !rev_closed_d_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_closed_d_reg <= 1'b0;
      rev_closed_d_reg <= 1'b0;
    end else begin
      start_closed_d_reg <= start_closed;
      rev_closed_d_reg <= db.select_input_c;
    end
  end

  // Run/stop command state
  // An open run/stop contact wins over every start, in every mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_state <= DSS_RUN_STOP;
    end else if (remote) begin
      if (!cfg.three_wire) begin
        if (!run_closed) begin
          run_state <= DSS_RUN_STOP;
        end else if (rev_enabled && db.select_input_c) begin
          run_state <= DSS_RUN_REV;
        end else if (start_closed) begin
          run_state <= DSS_RUN_FWD;
        end else begin
          run_state <= DSS_RUN_STOP;
        end
      end else begin
        if (!run_closed) begin
          run_state <= DSS_RUN_STOP;
        end else if (rev_rise) begin
          run_state <= DSS_RUN_REV;
        end else if (start_rise) begin
          run_state <= DSS_RUN_FWD;
        end
      end
    end else begin
      // Keypad start and stop in local
      if (key_stop || !run_closed) begin
        run_state <= DSS_RUN_STOP;
      end else if (key_run && run_state == DSS_RUN_STOP) begin
        run_state <= DSS_RUN_FWD;
      end
    end
  end

  // Auto/manual key with enter confirmation
  logic key_usable;
  logic key_auto_reg;
  logic [CCW-1:0] confirm_cnt_reg;

  // local needs local or speed setting
  assign key_usable = remote ? (cfg.automan_setting == DSS_AM_SPEED)
                             : (cfg.automan_setting == DSS_AM_LOCAL ||
                                cfg.automan_setting == DSS_AM_SPEED);

  // A repeated key press restarts the window
  // three second confirm window
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      automan_pending <= 1'b0;
      confirm_cnt_reg <= '0;
      key_auto_reg <= 1'b0;
    end else if (!key_usable) begin
      automan_pending <= 1'b0;
      confirm_cnt_reg <= '0;
    end else if (key_automan) begin
      automan_pending <= 1'b1;
      confirm_cnt_reg <= CCW'(CONFIRM_CYC);
    end else if (automan_pending) begin
      if (key_enter) begin
        automan_pending <= 1'b0;
        key_auto_reg <= !key_auto_reg;
      end else if (confirm_cnt_reg == CCW'(1)) begin
        automan_pending <= 1'b0;
      end
      confirm_cnt_reg <= confirm_cnt_reg - 1'b1;
    end
  end

  // Speed source decode
  logic auto_by_input;
  logic auto_input_closed;
  logic [2:0] preset_closed;
  logic [1:0] preset_count;
  dss_src_t ref_src;
  logic ref_found;
  logic auto_next;

  always_comb begin
    auto_by_input = 1'b0;
    auto_input_closed = 1'b0;
    preset_closed = 3'b000;
    for (int k = 0; k < 3; k++) begin
      if (fn[k] == DSS_SEL_AUTO) begin
        auto_by_input = 1'b1;
        auto_input_closed = auto_input_closed | sel[k];
      end
      if (fn[k] == DSS_SEL_PRESET) begin
        preset_closed[k] = sel[k];
      end
    end
  end

  assign preset_count = 2'(preset_closed[0]) + 2'(preset_closed[1]) + 2'(preset_closed[2]);

  always_comb begin
    ref_src = DSS_SRC_KEY;
    ref_found = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (sel[k]) begin
        if (fn[k] == DSS_SEL_VOLT) begin
          ref_src = DSS_SRC_VOLT;
          ref_found = 1'b1;
        end else if (fn[k] == DSS_SEL_CURR) begin
          ref_src = DSS_SRC_CURR;
          ref_found = 1'b1;
        end else if (fn[k] == DSS_SEL_PRESET) begin
          ref_src = dss_src_t'(3'(DSS_SRC_SP1) + 3'(k));
          ref_found = 1'b1;
        end
      end
    end
    if (preset_count >= 2'd2 && (ref_src == DSS_SRC_SP1 || ref_src == DSS_SRC_SP2 ||
        ref_src == DSS_SRC_SP3)) begin
      ref_src = DSS_SRC_SP4;
    end
  end

  // Keypad fallback changes only the source; auto_mode stays as chosen
  // auto input decides when key is unusable
  assign auto_next = (key_usable || !auto_by_input) ? (key_usable && key_auto_reg)
                                                    : auto_input_closed;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_mode <= 1'b0;
      speed_source <= DSS_SRC_KEY;
    end else begin
      auto_mode <= auto_next;
      speed_source <= (auto_next && ref_found) ? ref_src : DSS_SRC_KEY;
    end
  end

  // Contact speed trim
  logic [TCW-1:0] tick_cnt_reg;
  logic tick;
  logic down_on;
  logic up_on;
  logic [DSS_SPEED_W:0] up_sum;
  logic [DSS_SPEED_W:0] down_diff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // Free-running divider: one enable pulse per trim period
  assign tick = (tick_cnt_reg == TCW'(TRIM_TICK_CYC - 1));
  assign down_on = (cfg.func_a == DSS_SEL_DOWN) && db.select_input_a;
  assign up_on = (cfg.func_b == DSS_SEL_UP) && db.select_input_b &&
                 (run_state != DSS_RUN_STOP);
  assign up_sum = {1'b0, trim_setpoint} + {1'b0, trim_step};
  assign down_diff = {1'b0, trim_setpoint} - {1'b0, trim_step};

  // Down wins when both contacts close; a limit change pulls back next tick unless down is held above max or up is held below min
  // stepped and clamped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_setpoint <= DSS_SPEED_RST;
    end else if (tick) begin
      if (down_on) begin
        if (down_diff[DSS_SPEED_W] || down_diff[DSS_SPEED_W-1:0] < min_freq) begin
          trim_setpoint <= min_freq;
        end else begin
          trim_setpoint <= down_diff[DSS_SPEED_W-1:0];
        end
      end else if (up_on) begin
        if (up_sum[DSS_SPEED_W] || up_sum[DSS_SPEED_W-1:0] > max_freq) begin
          trim_setpoint <= max_freq;
        end else begin
          trim_setpoint <= up_sum[DSS_SPEED_W-1:0];
        end
      end else if (trim_setpoint < min_freq) begin
        trim_setpoint <= min_freq;
      end else if (trim_setpoint > max_freq) begin
        trim_setpoint <= max_freq;
      end
    end
  end

  // Status outputs
  function automatic logic out_level(input dss_out_t f, input dss_run_t r, input logic a);
    logic v;
    v = 1'b0;
    unique case (f)
      DSS_OUT_NONE: v = 1'b0;
      DSS_OUT_RUN: v = (r != DSS_RUN_STOP);
      DSS_OUT_AUTO: v = a;
      DSS_OUT_REV: v = (r == DSS_RUN_REV);
    endcase
    return v;
  endfunction

  // One clock behind the state so that each pin leaves a flip-flop
  // configured status outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sink_output_one <= 1'b0;
      sink_output_two <= 1'b0;
      relay_output <= 1'b0;
    end else begin
      sink_output_one <= out_level(cfg.func_out_one, run_state, auto_mode);
      sink_output_two <= out_level(cfg.func_out_two, run_state, auto_mode);
      relay_output <= out_level(cfg.func_relay, run_state, auto_mode);
    end
  end

endmodule

// ---- rtl/dss_debounce.sv ----
`timescale 1ns/1ps
module dss_debounce #(
  parameter int WIDTH = 5,
  parameter int HOLD_CYC = 400000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  localparam int CW = $clog2(HOLD_CYC + 1);

  initial begin
    if (WIDTH < 1 || HOLD_CYC < 1) begin
      $error("dss_debounce: bad parameters");
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic sync1_reg;
      logic sync2_reg;
      logic [CW-1:0] cnt_reg;
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
        end else begin
          sync1_reg <= raw[i];
          sync2_reg <= sync1_reg;
        end
      end
      // Settled level must hold for the full window
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_reg <= '0;
          clean[i] <= 1'b0;
        end else if (sync2_reg == clean[i]) begin
          cnt_reg <= '0;
        end else if (cnt_reg == CW'(HOLD_CYC - 1)) begin
          cnt_reg <= '0;
          clean[i] <= sync2_reg;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  endgenerate
endmodule

// ---- rtl/dss_pkg.sv ----
package dss_pkg;

  // Control source
  typedef enum logic [1:0] {
    DSS_CTL_LOCAL = 2'b00,
    DSS_CTL_REMOTE = 2'b01
  } dss_ctl_t;

  // Auto/manual parameter
  typedef enum logic [1:0] {
    DSS_AM_OFF = 2'b00,
    DSS_AM_LOCAL = 2'b01,
    DSS_AM_SPEED = 2'b10
  } dss_am_t;

  // Select input functions
  typedef enum logic [3:0] {
    DSS_SEL_NONE = 4'h0,
    DSS_SEL_VOLT = 4'h1,
    DSS_SEL_CURR = 4'h2,
    DSS_SEL_PRESET = 4'h3,
    DSS_SEL_DOWN = 4'h4,
    DSS_SEL_UP = 4'h5,
    DSS_SEL_AUTO = 4'h6,
    DSS_SEL_REV = 4'h7
  } dss_sel_t;

  // Speed source reported
  typedef enum logic [2:0] {
    DSS_SRC_KEY = 3'h0,
    DSS_SRC_VOLT = 3'h1,
    DSS_SRC_CURR = 3'h2,
    DSS_SRC_SP1 = 3'h3,
    DSS_SRC_SP2 = 3'h4,
    DSS_SRC_SP3 = 3'h5,
    DSS_SRC_SP4 = 3'h6
  } dss_src_t;

  // Status output functions
  typedef enum logic [1:0] {
    DSS_OUT_NONE = 2'b00,
    DSS_OUT_RUN = 2'b01,
    DSS_OUT_AUTO = 2'b10,
    DSS_OUT_REV = 2'b11
  } dss_out_t;

  typedef enum logic [1:0] {
    DSS_RUN_STOP = 2'b00,
    DSS_RUN_FWD = 2'b01,
    DSS_RUN_REV = 2'b10
  } dss_run_t;

  typedef struct packed {
    dss_ctl_t control_source;
    logic three_wire;
    dss_am_t automan_setting;
    dss_sel_t func_a;
    dss_sel_t func_b;
    dss_sel_t func_c;
    dss_out_t func_out_one;
    dss_out_t func_out_two;
    dss_out_t func_relay;
  } dss_cfg_t;

  typedef struct packed {
    logic run_stop_input;
    logic start_input;
    logic select_input_a;
    logic select_input_b;
    logic select_input_c;
  } dss_contacts_t;

  localparam int DSS_NUM_CONTACTS = 5;
  localparam int DSS_CLK_HZ = 40000000;
  localparam int DSS_DEBOUNCE_US = 10000;
  localparam int DSS_DEBOUNCE_CYC = DSS_DEBOUNCE_US * (DSS_CLK_HZ / 1000000);
  localparam int DSS_CONFIRM_MS = 3000;
  localparam int DSS_CONFIRM_CYC = DSS_CONFIRM_MS * (DSS_CLK_HZ / 1000);
  localparam int DSS_TRIM_TICK_MS = 10;
  localparam int DSS_TRIM_TICK_CYC = DSS_TRIM_TICK_MS * (DSS_CLK_HZ / 1000);
  localparam int DSS_SPEED_W = 16;
  localparam logic [15:0] DSS_SPEED_RST = 16'h0000;

endpackage

// ---- tb/dss_contact_model.sv ----
`timescale 1ns/1ps
module dss_contact_model
  import dss_pkg::*;
(
  input wire logic ref_clk,
  input dss_contacts_t want,
  input dss_contacts_t bounce,
  output dss_contacts_t pins
);
  logic flip = 1'b0;
  initial pins = '0;
  always @(posedge ref_clk) begin
    flip <= ~flip;
    pins <= want ^ (bounce & {DSS_NUM_CONTACTS{flip}});
  end
endmodule

// ---- tb/dss_control_sva.sv ----
`timescale 1ns/1ps
module dss_control_sva
  import dss_pkg::*;
#(
  parameter int CONFIRM_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input dss_cfg_t cfg,
  input dss_contacts_t contacts_closed,
  input wire logic key_run,
  input wire logic key_automan,
  input wire logic [DSS_SPEED_W-1:0] trim_step,
  input wire logic [DSS_SPEED_W-1:0] min_freq,
  input wire logic [DSS_SPEED_W-1:0] max_freq,
  input dss_run_t run_state,
  input wire logic auto_mode,
  input wire logic [DSS_SPEED_W-1:0] trim_setpoint,
  input wire logic automan_pending,
  input wire logic sink_output_one,
  input wire logic sink_output_two
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  int pend_cnt;
  // Length of an unconfirmed key press
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_cnt <= 0;
    end else if (key_automan || !automan_pending) begin
      pend_cnt <= 0;
    end else begin
      pend_cnt <= pend_cnt + 1;
    end
  end
  a_local_key_start: assert property (
    cfg.control_source == DSS_CTL_LOCAL && $rose(run_state != DSS_RUN_STOP)
    |-> $past(key_run) || $past(key_run, 2)) else $error("local start without key");
  a_rev_needs_c: assert property (
    cfg.func_c != DSS_SEL_REV |-> run_state != DSS_RUN_REV) else $error("reverse without C");
  a_open_run_stops: assert property (
    !contacts_closed.run_stop_input [*8] |-> ##2 run_state == DSS_RUN_STOP)
    else $error("open run contact did not stop");
  a_key_pending: assert property (
    key_automan && cfg.automan_setting == DSS_AM_SPEED |=> automan_pending)
    else $error("key press not held pending");
  a_confirm_window: assert property (
    pend_cnt <= CONFIRM_CYC + 2) else $error("pending outlived window");
  a_auto_status: assert property (
    cfg.func_out_one == DSS_OUT_AUTO |-> sink_output_one == $past(auto_mode))
    else $error("auto status wrong");
  a_run_status: assert property (
    cfg.func_out_two == DSS_OUT_RUN |-> sink_output_two == ($past(run_state) != DSS_RUN_STOP))
    else $error("run status wrong");
  a_up_when_run: assert property (
    $past(trim_setpoint) >= min_freq && trim_setpoint > $past(trim_setpoint)
    |-> $past(run_state) != DSS_RUN_STOP || $past(run_state, 2) != DSS_RUN_STOP)
    else $error("setpoint rose while stopped");
  a_trim_rate: assert property (
    $past(trim_setpoint) >= min_freq && trim_setpoint > $past(trim_setpoint)
    |-> trim_setpoint - $past(trim_setpoint) <= trim_step && trim_setpoint <= max_freq)
    else $error("setpoint step too large");
  c_fwd: cover property (run_state == DSS_RUN_FWD);
  c_rev: cover property (run_state == DSS_RUN_REV);
  c_auto: cover property (automan_pending ##[1:30] $rose(auto_mode));
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import dss_pkg::*;
  localparam int SET = 12;
  localparam int CONF = 20;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  dss_cfg_t cfg = '0;
  dss_contacts_t want = '0;
  dss_contacts_t bmask = '0;
  dss_contacts_t pins;
  logic [3:0] keys = 4'h0;
  logic [15:0] trim_step = 16'h0005;
  logic [15:0] min_freq = 16'h0010;
  logic [15:0] max_freq = 16'h0040;
  dss_run_t run_state;
  dss_src_t speed_source;
  logic [15:0] trim_setpoint;
  logic auto_mode;
  logic automan_pending;
  logic sink_output_one;
  logic sink_output_two;
  logic relay_output;
  int bad_count = 0;
  int cmp_count = 0;
  dss_contact_model u_sw (.ref_clk(ref_clk), .want(want), .bounce(bmask), .pins(pins));
  dss_control #(.DEBOUNCE_CYC(4), .CONFIRM_CYC(CONF), .TRIM_TICK_CYC(3)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg), .contacts_closed(pins),
    .key_run(keys[3]), .key_stop(keys[2]), .key_automan(keys[1]), .key_enter(keys[0]),
    .trim_step(trim_step), .min_freq(min_freq), .max_freq(max_freq),
    .run_state(run_state), .auto_mode(auto_mode), .speed_source(speed_source),
    .trim_setpoint(trim_setpoint), .automan_pending(automan_pending),
    .sink_output_one(sink_output_one), .sink_output_two(sink_output_two),
    .relay_output(relay_output));
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic miss(input logic [15:0] got, input logic [15:0] exp);
    bad_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) miss(got, exp);
  endtask
  task automatic chk_run(input dss_run_t got, input dss_run_t exp);
    cmp_count++;
    if (got !== exp) miss(16'(got), 16'(exp));
  endtask
  task automatic chk_src(input dss_src_t got, input dss_src_t exp);
    cmp_count++;
    if (got !== exp) miss(16'(got), 16'(exp));
  endtask
  task automatic put(input dss_contacts_t c, input int n);
    @(posedge ref_clk);
    want <= c;
    wt(n);
  endtask
  task automatic press(input logic [3:0] k, input int n);
    @(posedge ref_clk);
    keys <= k;
    @(posedge ref_clk);
    keys <= 4'h0;
    wt(n);
  endtask
  task automatic s_local();
    @(posedge ref_clk);
    cfg.automan_setting <= DSS_AM_LOCAL;
    cfg.func_out_one <= DSS_OUT_AUTO;
    cfg.func_out_two <= DSS_OUT_RUN;
    cfg.func_relay <= DSS_OUT_REV;
    put(5'h18, SET);
    chk_run(run_state, DSS_RUN_STOP);
    press(4'h8, 3);
    chk_run(run_state, DSS_RUN_FWD);
    press(4'h4, 3);
    chk_run(run_state, DSS_RUN_STOP);
  endtask
  task automatic s_automan();
    press(4'h2, 2);
    chk_val(automan_pending, 16'h0001);
    press(4'h1, 3);
    chk_val(auto_mode, 16'h0001);
    chk_src(speed_source, DSS_SRC_KEY);
    chk_val(sink_output_one, 16'h0001);
    press(4'h2, CONF + 6);
    chk_val(auto_mode, 16'h0001);
    chk_val(automan_pending, 16'h0000);
    @(posedge ref_clk);
    cfg.automan_setting <= DSS_AM_OFF;
    press(4'h2, 2);
    chk_val(automan_pending, 16'h0000);
    @(posedge ref_clk);
    cfg.automan_setting <= DSS_AM_LOCAL;
  endtask
  task automatic try_src(input dss_sel_t fa, input dss_sel_t fb, input dss_sel_t fc,
      input logic [2:0] abc, input dss_src_t exp);
    @(posedge ref_clk);
    cfg.func_a <= fa;
    cfg.func_b <= fb;
    cfg.func_c <= fc;
    put({2'h0, abc}, SET);
    chk_src(speed_source, exp);
    put(5'h00, SET);
  endtask
  task automatic s_remote_am();
    @(posedge ref_clk);
    cfg.control_source <= DSS_CTL_REMOTE;
    cfg.automan_setting <= DSS_AM_LOCAL;
    cfg.func_a <= DSS_SEL_AUTO;
    put(5'h04, SET);
    chk_val(auto_mode, 16'h0001);
    put(5'h00, SET);
    chk_val(auto_mode, 16'h0000);
    chk_val(sink_output_one, 16'h0000);
    press(4'h2, 2);
    chk_val(automan_pending, 16'h0000);
    @(posedge ref_clk);
    cfg.automan_setting <= DSS_AM_SPEED;
    press(4'h2, 2);
    chk_val(automan_pending, 16'h0001);
    wt(CONF + 4);
  endtask
  task automatic s_wires();
    @(posedge ref_clk);
    cfg.func_a <= DSS_SEL_NONE;
    put(5'h18, SET);
    chk_run(run_state, DSS_RUN_FWD);
    chk_val(sink_output_two, 16'h0001);
    bmask <= 5'h10;
    wt(2);
    bmask <= 5'h00;
    wt(SET);
    chk_run(run_state, DSS_RUN_FWD);
    put(5'h08, SET);
    chk_run(run_state, DSS_RUN_STOP);
    @(posedge ref_clk);
    cfg.func_c <= DSS_SEL_REV;
    put(5'h09, SET);
    put(5'h19, SET);
    chk_run(run_state, DSS_RUN_REV);
    chk_val(relay_output, 16'h0001);
    put(5'h00, SET);
    @(posedge ref_clk);
    cfg.func_c <= DSS_SEL_NONE;
    cfg.three_wire <= 1'b1;
    put(5'h10, SET);
    put(5'h18, SET);
    put(5'h10, SET);
    chk_run(run_state, DSS_RUN_FWD);
    put(5'h00, SET);
    put(5'h10, SET);
    chk_run(run_state, DSS_RUN_STOP);
  endtask
  task automatic s_trim();
    @(posedge ref_clk);
    cfg.three_wire <= 1'b0;
    cfg.func_a <= DSS_SEL_DOWN;
    cfg.func_b <= DSS_SEL_UP;
    put(5'h0a, 30);
    chk_val(trim_setpoint, min_freq);
    put(5'h1a, 60);
    chk_val(trim_setpoint, max_freq);
    put(5'h0c, 60);
    chk_val(trim_setpoint, min_freq);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #(25 * 5000);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    wt(2);
    s_local();
    s_automan();
    try_src(DSS_SEL_PRESET, DSS_SEL_PRESET, DSS_SEL_PRESET, 3'h4, DSS_SRC_SP1);
    try_src(DSS_SEL_PRESET, DSS_SEL_PRESET, DSS_SEL_PRESET, 3'h2, DSS_SRC_SP2);
    try_src(DSS_SEL_PRESET, DSS_SEL_PRESET, DSS_SEL_PRESET, 3'h1, DSS_SRC_SP3);
    try_src(DSS_SEL_PRESET, DSS_SEL_PRESET, DSS_SEL_PRESET, 3'h6, DSS_SRC_SP4);
    try_src(DSS_SEL_PRESET, DSS_SEL_PRESET, DSS_SEL_PRESET, 3'h3, DSS_SRC_SP4);
    try_src(DSS_SEL_VOLT, DSS_SEL_CURR, DSS_SEL_PRESET, 3'h7, DSS_SRC_SP3);
    try_src(DSS_SEL_VOLT, DSS_SEL_CURR, DSS_SEL_PRESET, 3'h6, DSS_SRC_CURR);
    try_src(DSS_SEL_VOLT, DSS_SEL_CURR, DSS_SEL_PRESET, 3'h4, DSS_SRC_VOLT);
    s_remote_am();
    s_wires();
    s_trim();
    give_verdict();
  end
endmodule
bind dss_control dss_control_sva #(.CONFIRM_CYC(CONFIRM_CYC)) u_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg), .contacts_closed(contacts_closed),
  .key_run(key_run), .key_automan(key_automan), .trim_step(trim_step),
  .min_freq(min_freq), .max_freq(max_freq), .run_state(run_state),
  .auto_mode(auto_mode), .trim_setpoint(trim_setpoint),
  .automan_pending(automan_pending), .sink_output_one(sink_output_one),
  .sink_output_two(sink_output_two));
